// ===== design/stb_cfg.svh
`ifndef STB_CFG_SVH
`define STB_CFG_SVH

// Address codes of the trim registers.
`define STB_ADDR_LOW_CLAMP 4'h1
`define STB_ADDR_HIGH_CLAMP 4'h2
`define STB_ADDR_QUIESCENT 4'h3
`define STB_ADDR_GAIN 4'h4
`define STB_ADDR_FILTER_CFG 4'h5
`define STB_ADDR_CUST_LOCK 4'h6
`define STB_ADDR_CONV_RESULT 4'h7
`define STB_ADDR_CONV_OFFSET 4'h8
`define STB_ADDR_OSC_TRIM 4'h9
`define STB_ADDR_LIN_TC 4'hB
`define STB_ADDR_QUAD_TC 4'hC
`define STB_ADDR_FACT_SET 4'hD
`define STB_ADDR_FACT_LOCK 4'hE
`define STB_ADDR_DESELECT 4'hF

// Field widths in bits.
`define STB_W_LOW_CLAMP 10
`define STB_W_HIGH_CLAMP 11
`define STB_W_QUIESCENT 11
`define STB_W_GAIN 14
`define STB_W_FILTER_CFG 6
`define STB_W_LOCK 1
`define STB_W_CONV 14
`define STB_W_CONV_OFFSET 5
`define STB_W_OSC_TRIM 5
`define STB_W_LIN_TC 6
`define STB_W_QUAD_TC 5
`define STB_W_FACT_SET 8
`define STB_W_DESELECT 12
`define STB_DATA_W 14

// Command codes.
`define STB_CMD_READ 3'h2
`define STB_CMD_WRITE 3'h3
`define STB_CMD_NV_PROGRAM 3'h4
`define STB_CMD_NV_ERASE 3'h5
`define STB_CMD_FACT_LOCK 3'h6
`define STB_CMD_CUST_LOCK 3'h7

// Value that deactivates the sensor.
`define STB_DESELECT_KEY 12'h80F

// Timing.
`define STB_CLK_HZ 25000000
`define STB_T_PROG_MS 100
`define STB_PROG_CYCLES (`STB_T_PROG_MS * (`STB_CLK_HZ / 1000))
`define STB_TIMER_W 22

`endif

// ===== design/stb_pkg.sv
package stb_pkg;
  `include "stb_cfg.svh"

  typedef struct packed {
    logic [`STB_W_LOW_CLAMP-1:0] low_clamp_level;
    logic [`STB_W_HIGH_CLAMP-1:0] high_clamp_level;
    logic [`STB_W_QUIESCENT-1:0] quiescent_output_level;
    logic [`STB_W_GAIN-1:0] gain_setting;
    logic [`STB_W_FILTER_CFG-1:0] filter_range_config;
    logic [`STB_W_LIN_TC-1:0] linear_temp_coeff;
    logic [`STB_W_QUAD_TC-1:0] quadratic_temp_coeff;
  } stb_cust_t;

  typedef enum logic [1:0] {
    STB_NV_IDLE,
    STB_NV_ERASE,
    STB_NV_PROGRAM,
    STB_NV_LOCK
  } stb_nv_op_t;

  typedef struct packed {
    stb_nv_op_t op;
    logic [`STB_TIMER_W-1:0] timer;
    stb_cust_t latch;
    stb_cust_t image;
    logic lock;
  } stb_nv_state_t;

  typedef struct packed {
    stb_cust_t ram;
    logic active;
    logic lock_active;
    logic rsp_valid;
    logic rsp_has_data;
    logic [`STB_DATA_W-1:0] rsp_data;
    logic act_meta;
    logic act_sync;
    logic act_prev;
    logic erase_go;
    logic program_go;
    logic lock_go;
  } stb_state_t;
endpackage : stb_pkg

// ===== design/stb_nvm.sv
`timescale 1ns/100ps
`include "stb_cfg.svh"

module stb_nvm
  import stb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `STB_PROG_CYCLES,
  parameter stb_cust_t IMAGE_INIT = '0,
  parameter bit LOCK_INIT = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Requests, one-cycle pulses, ignored while busy.
  input wire logic erase_req,
  input wire logic program_req,
  input wire logic lock_req,
  input wire stb_cust_t ram_image,
  // Stored contents and busy flag.
  output stb_cust_t nv_image,
  output logic nv_lock,
  output logic nv_busy
);

  initial begin
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << `STB_TIMER_W)) begin
      $error("stb_nvm: PROG_CYCLES out of range");
    end
  end

  stb_nv_state_t st;
  stb_nv_state_t next_st;

  // Cells change only at the end of the programming time; erase clears,
  // program can only set bits, so an erase must come first.
  always_comb begin
    next_st = st;
    unique case (st.op)
      STB_NV_IDLE: begin
        next_st.timer = `STB_TIMER_W'(PROG_CYCLES - 1);
        if (erase_req) begin
          next_st.op = STB_NV_ERASE;
        end else if (program_req) begin
          next_st.op = STB_NV_PROGRAM;
          next_st.latch = ram_image;
        end else if (lock_req) begin
          next_st.op = STB_NV_LOCK;
        end
      end
      STB_NV_ERASE, STB_NV_PROGRAM, STB_NV_LOCK: begin
        if (st.timer != '0) begin
          next_st.timer = st.timer - `STB_TIMER_W'(1);
        end else begin
          next_st.op = STB_NV_IDLE;
          if (st.op == STB_NV_ERASE) begin
            next_st.image = '0;
          end else if (st.op == STB_NV_PROGRAM) begin
            next_st.image = st.image | st.latch;
          end else begin
            next_st.lock = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st.op <= STB_NV_IDLE;
      st.timer <= '0;
      st.latch <= '0;
      st.image <= IMAGE_INIT;
      st.lock <= LOCK_INIT;
    end else begin
      st <= next_st;
    end
  end

  assign nv_image = st.image;
  assign nv_lock = st.lock;
  assign nv_busy = (st.op != STB_NV_IDLE);

endmodule : stb_nvm

// ===== design/stb_regs.sv
// Notes on behaviour
// - Signed-magnitude: leading bit sign, rest magnitude.
// - Two's complement: leading zero means positive.
// - Low clamp: 10 bits unsigned, code 1.
// - High clamp: 11 bits unsigned, code 2.
// - Quiescent output: 11-bit two's complement, code 3.
// - Gain: 14-bit signed-magnitude, code 4.
// - Linear temperature coefficient: 6-bit signed-magnitude, code 11.
// - Quadratic temperature coefficient: 5 bits, code 12.
// - Filter and range configuration: 6 bits, code 5.
// - Converter result at code 7 is read-only.
// - Writing 80F hex to code 15 deactivates.
// - Activate pulse or supply cycle reactivates.
// - Factory registers 8, 9, 13, 14 read-only.
// - Address field of erase and program ignored.
// - Erase and program act on all seven customer trim registers, not on the lock.
// - Customer lock takes effect after next power-up.
// - Codes: read 2, write 3, program 4, erase 5.
// - Write uses the trailing register-width data bits.
// - Read returns value in the leading data bits.
// - Fields travel most significant bit first.
`timescale 1ns/100ps
`include "stb_cfg.svh"

module stb_regs
  import stb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `STB_PROG_CYCLES,
  parameter stb_cust_t CUST_INIT = '0,
  parameter logic [`STB_W_CONV_OFFSET-1:0] CONV_OFFSET = '0,
  parameter logic [`STB_W_OSC_TRIM-1:0] OSC_TRIM = '0,
  parameter logic [`STB_W_FACT_SET-1:0] FACT_SETTINGS = '0,
  parameter bit FACT_LOCK = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Supply switched off and on again, one-cycle pulse.
  input wire logic supply_cycle,
  // Activate pulse level seen on the output pin.
  input wire logic activate_pin,
  // Decoded telegram, valid for one cycle.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic [`STB_DATA_W-1:0] cmd_data,
  // Converter sample from the signal path.
  input wire logic [`STB_W_CONV-1:0] conv_sample,
  // Answer telegram contents.
  output logic rsp_valid,
  output logic rsp_has_data,
  output logic [`STB_DATA_W-1:0] rsp_data,
  // Status.
  output logic sensor_active,
  output logic customer_locked,
  output logic nv_busy,
  // Trim values towards the signal path.
  output logic [`STB_W_LOW_CLAMP-1:0] low_clamp_level,
  output logic [`STB_W_HIGH_CLAMP-1:0] high_clamp_level,
  output logic signed [`STB_W_QUIESCENT-1:0] quiescent_output_level,
  output logic signed [`STB_W_GAIN-1:0] gain_value,
  output logic [`STB_W_FILTER_CFG-1:0] filter_range_config,
  output logic signed [`STB_W_LIN_TC-1:0] linear_tc_value,
  output logic [`STB_W_QUAD_TC-1:0] quadratic_temp_coeff
);

  initial begin
    if (PROG_CYCLES < 1) begin
      $error("stb_regs: PROG_CYCLES must be at least one");
    end
  end

  // Moves a field of the given width into the leading bits of the word.
  function automatic logic [`STB_DATA_W-1:0] lead_align(
    input logic [`STB_DATA_W-1:0] value,
    input int unsigned width
  );
    lead_align = value << (`STB_DATA_W - width);
  endfunction : lead_align

  // Turns a signed-magnitude field of the given width into two's complement.
  function automatic logic [`STB_DATA_W-1:0] sm_to_tc(
    input logic [`STB_DATA_W-1:0] value,
    input int unsigned width
  );
    logic [`STB_DATA_W-1:0] mag;
    logic neg;
    mag = value & ((`STB_DATA_W'(1) << (width - 1)) - `STB_DATA_W'(1));
    neg = value[width-1];
    sm_to_tc = neg ? (~mag + `STB_DATA_W'(1)) : mag;
  endfunction : sm_to_tc

  stb_state_t st;
  stb_state_t next_st;
  stb_cust_t nv_image;
  logic nv_lock;
  logic [`STB_DATA_W-1:0] rd_word;
  logic [`STB_DATA_W-1:0] gain_tc;
  logic [`STB_DATA_W-1:0] lin_tc;
  logic activate_edge;
  logic write_ok;
  logic nv_ok;
  logic nv_pend;

  stb_nvm #(
    .PROG_CYCLES(PROG_CYCLES),
    .IMAGE_INIT(CUST_INIT),
    .LOCK_INIT(1'b0)
  ) u_nvm (
    .core_clk(core_clk),
    .reset(reset),
    .erase_req(st.erase_go),
    .program_req(st.program_go),
    .lock_req(st.lock_go),
    .ram_image(st.ram),
    .nv_image(nv_image),
    .nv_lock(nv_lock),
    .nv_busy(nv_busy)
  );

  assign activate_edge = st.act_sync & ~st.act_prev;
  // A request already handed to the storage counts as busy, so a second
  // one in the next cycle is refused instead of acknowledged and lost.
  assign nv_pend = st.erase_go | st.program_go | st.lock_go;
  assign write_ok = ~st.lock_active & ~nv_busy & ~nv_pend;
  assign nv_ok = write_ok;

  // Read data for the addressed register, leading-bit aligned.
  always_comb begin
    rd_word = '0;
    unique case (cmd_addr)
      `STB_ADDR_LOW_CLAMP: rd_word = lead_align(
        `STB_DATA_W'(st.ram.low_clamp_level), `STB_W_LOW_CLAMP);
      `STB_ADDR_HIGH_CLAMP: rd_word = lead_align(
        `STB_DATA_W'(st.ram.high_clamp_level), `STB_W_HIGH_CLAMP);
      `STB_ADDR_QUIESCENT: rd_word = lead_align(
        `STB_DATA_W'(st.ram.quiescent_output_level),
        `STB_W_QUIESCENT);
      `STB_ADDR_GAIN: rd_word = st.ram.gain_setting;
      `STB_ADDR_FILTER_CFG: rd_word = lead_align(
        `STB_DATA_W'(st.ram.filter_range_config),
        `STB_W_FILTER_CFG);
      `STB_ADDR_CUST_LOCK: rd_word = lead_align(
        `STB_DATA_W'(nv_lock), `STB_W_LOCK);
      `STB_ADDR_CONV_RESULT: rd_word = conv_sample;
      `STB_ADDR_CONV_OFFSET: rd_word = lead_align(
        `STB_DATA_W'(CONV_OFFSET), `STB_W_CONV_OFFSET);
      `STB_ADDR_OSC_TRIM: rd_word = lead_align(
        `STB_DATA_W'(OSC_TRIM), `STB_W_OSC_TRIM);
      `STB_ADDR_LIN_TC: rd_word = lead_align(
        `STB_DATA_W'(st.ram.linear_temp_coeff), `STB_W_LIN_TC);
      `STB_ADDR_QUAD_TC: rd_word = lead_align(
        `STB_DATA_W'(st.ram.quadratic_temp_coeff),
        `STB_W_QUAD_TC);
      `STB_ADDR_FACT_SET: rd_word = lead_align(
        `STB_DATA_W'(FACT_SETTINGS), `STB_W_FACT_SET);
      `STB_ADDR_FACT_LOCK: rd_word = lead_align(
        `STB_DATA_W'(FACT_LOCK), `STB_W_LOCK);
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_has_data = 1'b0;
    next_st.erase_go = 1'b0;
    next_st.program_go = 1'b0;
    next_st.lock_go = 1'b0;
    next_st.act_meta = activate_pin;
    next_st.act_sync = st.act_meta;
    next_st.act_prev = st.act_sync;

    if (cmd_valid && st.active) begin
      unique case (cmd_code)
        `STB_CMD_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_has_data = 1'b1;
          next_st.rsp_data = rd_word;
        end
        `STB_CMD_WRITE: begin
          if (write_ok) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data = '0;
            // Only the trailing bits of the data field are taken.
            unique case (cmd_addr)
              `STB_ADDR_LOW_CLAMP: next_st.ram.low_clamp_level =
                cmd_data[`STB_W_LOW_CLAMP-1:0];
              `STB_ADDR_HIGH_CLAMP: next_st.ram.high_clamp_level =
                cmd_data[`STB_W_HIGH_CLAMP-1:0];
              `STB_ADDR_QUIESCENT: next_st.ram.quiescent_output_level =
                cmd_data[`STB_W_QUIESCENT-1:0];
              `STB_ADDR_GAIN: next_st.ram.gain_setting =
                cmd_data[`STB_W_GAIN-1:0];
              `STB_ADDR_FILTER_CFG: next_st.ram.filter_range_config =
                cmd_data[`STB_W_FILTER_CFG-1:0];
              `STB_ADDR_LIN_TC: next_st.ram.linear_temp_coeff =
                cmd_data[`STB_W_LIN_TC-1:0];
              `STB_ADDR_QUAD_TC: next_st.ram.quadratic_temp_coeff =
                cmd_data[`STB_W_QUAD_TC-1:0];
              `STB_ADDR_CUST_LOCK: next_st.lock_go = cmd_data[0];
              `STB_ADDR_DESELECT: begin
                if (cmd_data[`STB_W_DESELECT-1:0] == `STB_DESELECT_KEY) begin
                  next_st.active = 1'b0;
                end
              end
              default: next_st.ram = st.ram;
            endcase
          end
        end
        `STB_CMD_NV_PROGRAM: begin
          // The address field plays no part here.
          if (nv_ok) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data = '0;
            next_st.program_go = 1'b1;
          end
        end
        `STB_CMD_NV_ERASE: begin
          if (nv_ok) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data = '0;
            next_st.erase_go = 1'b1;
          end
        end
        `STB_CMD_CUST_LOCK: begin
          if (nv_ok) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data = '0;
            next_st.lock_go = 1'b1;
          end
        end
        default: next_st.rsp_valid = 1'b0;
      endcase
    end

    // The lock written now only counts from the next power-up on.
    if (supply_cycle) begin
      next_st.ram = nv_image;
      next_st.lock_active = nv_lock;
      next_st.active = 1'b1;
      next_st.rsp_valid = 1'b0;
      next_st.erase_go = 1'b0;
      next_st.program_go = 1'b0;
      next_st.lock_go = 1'b0;
    end else if (activate_edge) begin
      next_st.active = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st.ram <= CUST_INIT;
      st.active <= 1'b1;
      st.lock_active <= 1'b0;
      st.rsp_valid <= 1'b0;
      st.rsp_has_data <= 1'b0;
      st.rsp_data <= '0;
      st.act_meta <= 1'b0;
      st.act_sync <= 1'b0;
      st.act_prev <= 1'b0;
      st.erase_go <= 1'b0;
      st.program_go <= 1'b0;
      st.lock_go <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign gain_tc = sm_to_tc(st.ram.gain_setting, `STB_W_GAIN);
  assign lin_tc = sm_to_tc(`STB_DATA_W'(st.ram.linear_temp_coeff),
    `STB_W_LIN_TC);

  assign rsp_valid = st.rsp_valid;
  assign rsp_has_data = st.rsp_has_data;
  assign rsp_data = st.rsp_data;
  assign sensor_active = st.active;
  assign customer_locked = st.lock_active;
  assign low_clamp_level = st.ram.low_clamp_level;
  assign high_clamp_level = st.ram.high_clamp_level;
  assign quiescent_output_level = st.ram.quiescent_output_level;
  assign gain_value = gain_tc;
  assign filter_range_config = st.ram.filter_range_config;
  assign linear_tc_value = lin_tc[`STB_W_LIN_TC-1:0];
  assign quadratic_temp_coeff = st.ram.quadratic_temp_coeff;

endmodule : stb_regs

// ===== tb/stb_regs_chk.sv
`timescale 1ns/100ps
`include "stb_cfg.svh"
module stb_regs_chk
  import stb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 8
) (
  // Clock, reset and stimulus.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic supply_cycle,
  input wire logic activate_pin,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic [13:0] cmd_data,
  input wire logic [13:0] conv_sample,
  // Answers, status and trims.
  input wire logic rsp_valid,
  input wire logic rsp_has_data,
  input wire logic [13:0] rsp_data,
  input wire logic sensor_active,
  input wire logic customer_locked,
  input wire logic nv_busy,
  input wire logic [9:0] low_clamp_level,
  input wire logic [10:0] high_clamp_level,
  input wire logic signed [10:0] quiescent_output_level,
  input wire logic signed [13:0] gain_value,
  input wire logic [5:0] filter_range_config,
  input wire logic signed [5:0] linear_tc_value,
  input wire logic [4:0] quadratic_temp_coeff
);
  logic take;
  logic nv_ok;
  logic wr_ok;
  logic nv_pend;
  int unsigned busy_cnt;
  assign take = cmd_valid && sensor_active && !supply_cycle;
  assign nv_ok = take && !customer_locked && !nv_busy && !nv_pend;
  assign wr_ok = nv_ok && cmd_code == `STB_CMD_WRITE;
  function automatic logic [13:0] sm14(input logic [13:0] v);
    return v[13] ? ~{1'b0, v[12:0]} + 14'h1 : {1'b0, v[12:0]};
  endfunction : sm14
  always_ff @(posedge core_clk) begin
    if (reset || !nv_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
    nv_pend <= !reset && nv_ok && (cmd_code inside {`STB_CMD_NV_PROGRAM,
      `STB_CMD_NV_ERASE, `STB_CMD_CUST_LOCK} || cmd_code == `STB_CMD_WRITE
      && cmd_addr == 4'h6 && cmd_data[0]);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  read_ack_a: assert property (
    take && cmd_code == `STB_CMD_READ |=> rsp_valid && rsp_has_data)
    else $error("read not answered");
  bad_code_a: assert property (
    cmd_valid && cmd_code inside {3'h0, 3'h1, 3'h6} |=> !rsp_valid)
    else $error("refused code answered");
  read_left_a: assert property (
    take && cmd_code == `STB_CMD_READ && cmd_addr == 4'h1
    |=> rsp_data == {$past(low_clamp_level), 4'h0})
    else $error("clamp read misaligned");
  write_right_a: assert property (
    wr_ok && cmd_addr == 4'h1 |=> low_clamp_level == $past(cmd_data[9:0]))
    else $error("clamp write wrong bits");
  gain_sm_a: assert property (
    wr_ok && cmd_addr == 4'h4 |=> gain_value == sm14($past(cmd_data)))
    else $error("gain conversion wrong");
  ro_keep_a: assert property (
    take && cmd_code == `STB_CMD_WRITE
    && cmd_addr inside {4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hE}
    |=> $stable(low_clamp_level) && $stable(gain_value))
    else $error("read-only write changed a trim");
  deselect_a: assert property (
    wr_ok && cmd_addr == 4'hF && cmd_data[11:0] == `STB_DESELECT_KEY
    |=> rsp_valid && !sensor_active)
    else $error("deselect key ignored");
  inactive_a: assert property (
    cmd_valid && !sensor_active |=> !rsp_valid)
    else $error("inactive sensor answered");
  nv_start_a: assert property (
    nv_ok && cmd_code inside {`STB_CMD_NV_PROGRAM, `STB_CMD_NV_ERASE}
    |=> rsp_valid ##1 nv_busy)
    else $error("nv operation did not start");
  nv_len_a: assert property (
    $fell(nv_busy) && !$past(reset) |-> busy_cnt == PROG_CYCLES)
    else $error("nv busy length wrong");
  lock_quiet_a: assert property (
    customer_locked && cmd_valid && cmd_code == `STB_CMD_WRITE |=> !rsp_valid)
    else $error("locked write answered");
  cover property (wr_ok && cmd_addr == 4'hF);
  cover property ($fell(nv_busy));
  cover property (customer_locked && cmd_valid);
endmodule : stb_regs_chk

// ===== tb/stb_prog_model.sv
`timescale 1ns/100ps
module stb_prog_model (
  // Clock and answer from the sensor.
  input wire logic core_clk,
  input wire logic rsp_valid,
  input wire logic [13:0] rsp_data,
  // Decoded telegram towards the sensor.
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [3:0] cmd_addr,
  output logic [13:0] cmd_data
);
  logic got;
  logic [13:0] q;
  int idle = 0;
  initial begin
    {cmd_valid, cmd_code, cmd_addr, cmd_data} = '0;
  end
  // Codes are 3-bit binary; cmd_data[13] is the first data bit sent.
  task automatic send(input logic [2:0] c, input logic [3:0] a,
                      input logic [13:0] d);
    repeat (idle) @(posedge core_clk);
    @(posedge core_clk);
    #1 {cmd_valid, cmd_code, cmd_addr, cmd_data} = {1'b1, c, a, d};
    @(posedge core_clk);
    #1 got = rsp_valid;
    q = rsp_data;
    // Released fields show the inverse so a stale value is never reused.
    {cmd_valid, cmd_code, cmd_addr, cmd_data} = {1'b0, ~c, ~a, ~d};
  endtask : send
endmodule : stb_prog_model

// ===== tb/tb_sensor_trim_register_bank.sv
`timescale 1ns/100ps
`include "stb_cfg.svh"
module tb_sensor_trim_register_bank
  import stb_pkg::*;
;
  logic core_clk, reset, supply_cycle, activate_pin;
  logic cmd_valid, rsp_valid, rsp_has_data;
  logic [2:0] cmd_code;
  logic [3:0] cmd_addr;
  logic [13:0] cmd_data, conv_sample, rsp_data;
  logic sensor_active, customer_locked, nv_busy;
  logic [9:0] low_clamp_level;
  logic [10:0] high_clamp_level;
  logic signed [10:0] quiescent_output_level;
  logic signed [13:0] gain_value;
  logic [5:0] filter_range_config;
  logic signed [5:0] linear_tc_value;
  logic [4:0] quadratic_temp_coeff;
  int bad_count, checks;
  logic [31:0] seed;
  logic [13:0] val [7];
  logic [3:0] rw_a [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB, 4'hC};
  int rw_w [7] = '{10, 11, 11, 14, 6, 6, 5};
  logic [3:0] ro_a [7] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hE};
  logic [2:0] bad_code [3] = '{3'h0, 3'h1, 3'h6};

  stb_regs #(.PROG_CYCLES(8)) dut (.*);
  stb_prog_model m (.*);

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [13:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[13:0];
  endfunction : rnd
  function automatic logic [13:0] align(input logic [13:0] d, input int w);
    return (d & (14'h3FFF >> (14 - w))) << (14 - w);
  endfunction : align
  function automatic logic [13:0] sm(input logic [13:0] d, input int w);
    logic [13:0] mag;
    mag = d & (14'h3FFF >> (15 - w));
    return d[w-1] ? 14'h0 - mag : mag;
  endfunction : sm

  task automatic chk_word(input string n, input logic [13:0] e,
                          input logic [13:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_flag(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask : chk_flag
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pulse_supply();
    tick();
    supply_cycle = 1;
    tick();
    supply_cycle = 0;
  endtask : pulse_supply
  task automatic nv_wait();
    tick();
    chk_flag("nv busy", 1'b1, nv_busy);
    for (int i = 0; i < 20 && nv_busy; i++) tick();
    chk_flag("nv done", 1'b0, nv_busy);
  endtask : nv_wait
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    seed = 94853;
    {reset, supply_cycle, activate_pin} = 3'b100;
    conv_sample = 14'h0;
    bad_count = 0;
    checks = 0;
    repeat (4) tick();
    reset = 0;
    conv_sample = rnd();
    // Stage all working copies, then one erase and one program.
    for (int i = 0; i < 7; i++) begin
      val[i] = (i == 0) ? 14'h3FFF : rnd();
      m.idle = rnd() % 3;
      m.send(`STB_CMD_WRITE, rw_a[i], val[i]);
      chk_flag("write ack", 1'b1, m.got);
    end
    m.idle = 0;
    chk_word("low", 14'h3FF, 14'(low_clamp_level));
    chk_word("high", 14'(val[1][10:0]), 14'(high_clamp_level));
    chk_word("filter", 14'(val[4][5:0]), 14'(filter_range_config));
    chk_word("quad", 14'(val[6][4:0]), 14'(quadratic_temp_coeff));
    chk_word("quiescent", 14'($signed(val[2][10:0])),
             14'(quiescent_output_level));
    chk_word("gain", sm(val[3], 14), gain_value);
    chk_word("lin tc", sm(val[5], 6), 14'(linear_tc_value));
    m.send(`STB_CMD_NV_ERASE, 4'(rnd()), 14'h0);
    nv_wait();
    m.send(`STB_CMD_NV_PROGRAM, 4'(rnd()), 14'h0);
    nv_wait();
    for (int i = 0; i < 7; i++) begin
      m.send(`STB_CMD_READ, rw_a[i], 14'h0);
      chk_word("read", align(val[i], rw_w[i]), m.q);
    end
    m.send(`STB_CMD_WRITE, 4'h1, 14'h0055);
    pulse_supply();
    m.send(`STB_CMD_READ, 4'h1, 14'h0);
    chk_word("stored", 14'h3FF0, m.q);
    for (int i = 0; i < 7; i++) begin
      m.send(`STB_CMD_WRITE, ro_a[i], rnd());
      chk_word("ro low", 14'h3FF, 14'(low_clamp_level));
      chk_word("ro gain", sm(val[3], 14), gain_value);
    end
    m.send(`STB_CMD_READ, 4'h7, 14'h0);
    chk_word("conv", conv_sample, m.q);
    m.send(`STB_CMD_READ, 4'hE, 14'h0);
    chk_word("fact lock", 14'h2000, m.q);
    foreach (bad_code[i]) begin
      m.send(bad_code[i], 4'h1, 14'h0);
      chk_flag("refused", 1'b0, m.got);
    end
    m.send(`STB_CMD_WRITE, 4'hF, 14'h080E);
    chk_flag("near key", 1'b1, sensor_active);
    m.send(`STB_CMD_WRITE, 4'hF, 14'h080F);
    chk_flag("deselect", 1'b0, sensor_active);
    m.send(`STB_CMD_READ, 4'h1, 14'h0);
    chk_flag("silent", 1'b0, m.got);
    activate_pin = 1;
    repeat (3) tick();
    activate_pin = 0;
    repeat (6) tick();
    chk_flag("activate", 1'b1, sensor_active);
    m.send(`STB_CMD_WRITE, 4'hF, 14'h080F);
    pulse_supply();
    chk_flag("power up", 1'b1, sensor_active);
    m.send(`STB_CMD_CUST_LOCK, 4'h6, 14'h0);
    nv_wait();
    chk_flag("lock later", 1'b0, customer_locked);
    pulse_supply();
    chk_flag("lock on", 1'b1, customer_locked);
    m.send(`STB_CMD_WRITE, 4'h1, 14'h0);
    chk_flag("locked wr", 1'b0, m.got);
    give_verdict();
  end
endmodule : tb_sensor_trim_register_bank

bind stb_regs stb_regs_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (.*);
